// [smtts_params.svh]
`ifndef SMTTS_PARAMS_SVH
`define SMTTS_PARAMS_SVH

// ==========================================================
// Memory-mapped status offsets
`define SMTTS_OFF_TOP        8'h00
`define SMTTS_OFF_TOP_RC     8'h02
`define SMTTS_OFF_MIRROR     8'h04
`define SMTTS_OFF_STAT_RC    8'h06

// ==========================================================
// Configuration indices holding trap and timer enables, and the excluded bridge index range
`define SMTTS_IDX_HDR_EN_A   8'h41
`define SMTTS_IDX_HDR_EN_B   8'h42
`define SMTTS_IDX_UD_EN      8'h82
`define SMTTS_IDX_TMR_EN     8'h83
`define SMTTS_IDX_EXCL_LO    8'h40
`define SMTTS_IDX_EXCL_HI    8'h43

// ==========================================================
// Enable bit positions
`define SMTTS_EN_FN0_BIT     0
`define SMTTS_EN_FN1_BIT     3
`define SMTTS_EN_FN2_BIT     6
`define SMTTS_EN_FN3_BIT     0
`define SMTTS_EN_FN4_BIT     1
`define SMTTS_EN_UD1_BIT     4
`define SMTTS_EN_UD2_BIT     5
`define SMTTS_EN_UD3_BIT     6
`define SMTTS_EN_TMR1_BIT    0
`define SMTTS_EN_TMR2_BIT    1

// ==========================================================
// Second-level status bit positions
`define SMTTS_ST_TMR1        0
`define SMTTS_ST_TMR2        1
`define SMTTS_ST_UD1         2
`define SMTTS_ST_UD2         3
`define SMTTS_ST_UD3         4
`define SMTTS_ST_HDR         5
`define SMTTS_ST_WIDTH       6

// ==========================================================
// Top-level status bit positions
`define SMTTS_TOP_EVT0       0
`define SMTTS_TOP_EVT1       1
`define SMTTS_TOP_SECOND     9

// ==========================================================
// Reset values
`define SMTTS_RST_WORD       16'h0000
`define SMTTS_RST_CFG        8'h00
`define SMTTS_RST_STAT       6'h00
`define SMTTS_RST_TOP        2'h0

`endif

// [smtts_pkg.sv]
package smtts_pkg;

	typedef logic [15:0] smtts_word_t;
	typedef logic [5:0]  smtts_stat_t;
	typedef logic [7:0]  smtts_byte_t;

	typedef enum logic [2:0] {
		SMTTS_FN_BRIDGE  = 3'h0,
		SMTTS_FN_PWRMGMT = 3'h1,
		SMTTS_FN_DISK    = 3'h2,
		SMTTS_FN_SOUND   = 3'h3,
		SMTTS_FN_DISPLAY = 3'h4
	} smtts_func_e;

	typedef enum logic {
		SMTTS_RD_IDLE = 1'b0,
		SMTTS_RD_ANS  = 1'b1
	} smtts_rd_e;

endpackage

// [smtts_evt_if.sv]
`timescale 1ns/1ps

interface smtts_evt_if;
	smtts_pkg::smtts_stat_t set_vec;
	logic                   clr;
	smtts_pkg::smtts_stat_t status;

	modport decode (output set_vec);
	modport bank   (input set_vec, input clr, output status);
	modport top    (output clr, input status);
endinterface

// [smtts_trap_decode.sv]
`timescale 1ns/1ps
`include "smtts_params.svh"

module smtts_trap_decode (
	// Header trap event
	input  wire logic                   hdr_trap_stb,
	input  wire smtts_pkg::smtts_func_e hdr_trap_func,
	input  wire smtts_pkg::smtts_byte_t hdr_trap_idx,
	// Device and timer events
	input  wire logic [2:0]             ud_hit,
	input  wire logic [1:0]             tmr_expire,
	// Enable registers
	input  wire smtts_pkg::smtts_byte_t en_hdr_a,
	input  wire smtts_pkg::smtts_byte_t en_hdr_b,
	input  wire smtts_pkg::smtts_byte_t en_ud,
	input  wire smtts_pkg::smtts_byte_t en_tmr,
	// Set requests
	smtts_evt_if.decode                 evt
);
	import smtts_pkg::*;

	function automatic logic hdr_enabled(smtts_func_e f, smtts_byte_t idx,
			smtts_byte_t a, smtts_byte_t b);
		logic en;
		en = 1'b0;
		unique case (f)
			SMTTS_FN_BRIDGE: begin
				en = a[`SMTTS_EN_FN0_BIT] &&
					!(idx >= `SMTTS_IDX_EXCL_LO && idx <= `SMTTS_IDX_EXCL_HI);
			end
			SMTTS_FN_PWRMGMT: en = a[`SMTTS_EN_FN1_BIT];
			SMTTS_FN_DISK:    en = a[`SMTTS_EN_FN2_BIT];
			SMTTS_FN_SOUND:   en = b[`SMTTS_EN_FN3_BIT];
			SMTTS_FN_DISPLAY: en = b[`SMTTS_EN_FN4_BIT];
			default:          en = 1'b0;
		endcase
		return en;
	endfunction

	always_comb begin
		evt.set_vec = '0;
		evt.set_vec[`SMTTS_ST_HDR] = hdr_trap_stb &&
			hdr_enabled(hdr_trap_func, hdr_trap_idx, en_hdr_a, en_hdr_b);
		evt.set_vec[`SMTTS_ST_UD3] = ud_hit[2] && en_ud[`SMTTS_EN_UD3_BIT];
		evt.set_vec[`SMTTS_ST_UD2] = ud_hit[1] && en_ud[`SMTTS_EN_UD2_BIT];
		evt.set_vec[`SMTTS_ST_UD1] = ud_hit[0] && en_ud[`SMTTS_EN_UD1_BIT];
		evt.set_vec[`SMTTS_ST_TMR2] = tmr_expire[1] &&
			en_tmr[`SMTTS_EN_TMR2_BIT];
		evt.set_vec[`SMTTS_ST_TMR1] = tmr_expire[0] &&
			en_tmr[`SMTTS_EN_TMR1_BIT];
	end

endmodule // smtts_trap_decode

// [smtts_status_bank.sv]
`timescale 1ns/1ps
`include "smtts_params.svh"

module smtts_status_bank (
	// Clock and reset
	input  wire logic mclk,
	input  wire logic rst,
	// Set, clear and status
	smtts_evt_if.bank evt
);
	import smtts_pkg::*;

	smtts_stat_t stat_r;

	// ==========================================================
	// Sticky bits; a set in the clearing cycle survives
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			stat_r <= `SMTTS_RST_STAT;
		end else if (evt.clr) begin
			stat_r <= evt.set_vec;
		end else begin
			stat_r <= stat_r | evt.set_vec;
		end
	end

	assign evt.status = stat_r;

endmodule // smtts_status_bank

// [smtts_top.sv]
`timescale 1ns/1ps
`include "smtts_params.svh"

module smtts_top (
	// Clock and reset
	input  wire logic                   mclk,
	input  wire logic                   rst,
	// Memory-mapped status reads
	input  wire logic                   mem_rd_stb,
	input  wire smtts_pkg::smtts_byte_t mem_addr,
	output smtts_pkg::smtts_word_t      mem_rd_data,
	output logic                        mem_rd_ack,
	output logic                        mem_rd_err,
	// Configuration index access
	input  wire logic                   cfg_wr_stb,
	input  wire logic                   cfg_rd_stb,
	input  wire smtts_pkg::smtts_byte_t cfg_idx,
	input  wire smtts_pkg::smtts_byte_t cfg_wdata,
	output smtts_pkg::smtts_byte_t      cfg_rdata,
	output logic                        cfg_rd_ack,
	// Header trap event
	input  wire logic                   hdr_trap_stb,
	input  wire smtts_pkg::smtts_func_e hdr_trap_func,
	input  wire smtts_pkg::smtts_byte_t hdr_trap_idx,
	// Device traps, timers, other top-level sources
	input  wire logic [2:0]             ud_hit,
	input  wire logic [1:0]             tmr_expire,
	input  wire logic [1:0]             top_evt,
	// Management interrupt and status view
	output logic                        system_mgmt_irq,
	output smtts_pkg::smtts_stat_t      trap_status
);
	import smtts_pkg::*;

	// ==========================================================
	// Declarations
	smtts_evt_if evt ();

	smtts_byte_t en_hdr_a_r;
	smtts_byte_t en_hdr_b_r;
	smtts_byte_t en_ud_r;
	smtts_byte_t en_tmr_r;
	logic [1:0]  top_r;
	smtts_word_t top_word;
	smtts_word_t mirror_word;
	smtts_word_t rd_nxt;
	logic        rd_hit_nxt;
	logic        rd_clr_second;
	logic        rd_clr_top;
	smtts_rd_e   rd_state_r;
	smtts_word_t rd_data_r;
	logic        rd_err_r;
	smtts_byte_t cfg_rdata_r;
	logic        cfg_ack_r;
	logic        irq_r;
	smtts_stat_t trap_status_r;

	// ==========================================================
	// Shared decode of a status word from its sources
	function automatic smtts_word_t second_word(smtts_stat_t s);
		smtts_word_t w;
		w = `SMTTS_RST_WORD;
		w[`SMTTS_ST_WIDTH-1:0] = s;
		return w;
	endfunction

	function automatic smtts_word_t top_level_word(smtts_stat_t s,
			logic [1:0] t);
		smtts_word_t w;
		w = `SMTTS_RST_WORD;
		w[`SMTTS_TOP_SECOND] = |s;
		w[`SMTTS_TOP_EVT1]   = t[1];
		w[`SMTTS_TOP_EVT0]   = t[0];
		return w;
	endfunction

	// ==========================================================
	// Event qualification and sticky status
	smtts_trap_decode u_decode (
		.hdr_trap_stb  (hdr_trap_stb),
		.hdr_trap_func (hdr_trap_func),
		.hdr_trap_idx  (hdr_trap_idx),
		.ud_hit        (ud_hit),
		.tmr_expire    (tmr_expire),
		.en_hdr_a      (en_hdr_a_r),
		.en_hdr_b      (en_hdr_b_r),
		.en_ud         (en_ud_r),
		.en_tmr        (en_tmr_r),
		.evt           (evt.decode)
	);

	smtts_status_bank u_bank (
		.mclk (mclk),
		.rst  (rst),
		.evt  (evt.bank)
	);

	// ==========================================================
	// Enable registers at their configuration indices
	// One block per index; writes to other indices are dropped
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			en_hdr_a_r <= `SMTTS_RST_CFG;
		end else if (cfg_wr_stb && cfg_idx == `SMTTS_IDX_HDR_EN_A) begin
			en_hdr_a_r <= cfg_wdata;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			en_hdr_b_r <= `SMTTS_RST_CFG;
		end else if (cfg_wr_stb && cfg_idx == `SMTTS_IDX_HDR_EN_B) begin
			en_hdr_b_r <= cfg_wdata;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			en_ud_r <= `SMTTS_RST_CFG;
		end else if (cfg_wr_stb && cfg_idx == `SMTTS_IDX_UD_EN) begin
			en_ud_r <= cfg_wdata;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			en_tmr_r <= `SMTTS_RST_CFG;
		end else if (cfg_wr_stb && cfg_idx == `SMTTS_IDX_TMR_EN) begin
			en_tmr_r <= cfg_wdata;
		end
	end

	// Index reads answer one cycle later; unknown indices read zero
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cfg_ack_r <= 1'b0;
		end else begin
			cfg_ack_r <= cfg_rd_stb;
		end
	end

	// Data holds until the next index read
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cfg_rdata_r <= `SMTTS_RST_CFG;
		end else if (cfg_rd_stb) begin
			unique case (cfg_idx)
				`SMTTS_IDX_HDR_EN_A: cfg_rdata_r <= en_hdr_a_r;
				`SMTTS_IDX_HDR_EN_B: cfg_rdata_r <= en_hdr_b_r;
				`SMTTS_IDX_UD_EN:    cfg_rdata_r <= en_ud_r;
				`SMTTS_IDX_TMR_EN:   cfg_rdata_r <= en_tmr_r;
				default:             cfg_rdata_r <= `SMTTS_RST_CFG;
			endcase
		end
	end

	assign cfg_rdata  = cfg_rdata_r;
	assign cfg_rd_ack = cfg_ack_r;

	// ==========================================================
	// Top-level sticky sources behind bits 1 and 0
	// Bit 9 is not stored: it follows the second level directly,
	// so it can never disagree with the detail below it.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			top_r <= `SMTTS_RST_TOP;
		end else if (rd_clr_top) begin
			top_r <= top_evt;
		end else begin
			top_r <= top_r | top_evt;
		end
	end

	assign top_word    = top_level_word(evt.status, top_r);
	assign mirror_word = second_word(evt.status);

	// ==========================================================
	// Read decode
	always_comb begin
		rd_nxt     = `SMTTS_RST_WORD;
		rd_hit_nxt = 1'b1;
		unique case (mem_addr)
			`SMTTS_OFF_TOP: begin
				rd_nxt = top_word;
			end
			`SMTTS_OFF_TOP_RC: begin
				rd_nxt = top_word;
			end
			`SMTTS_OFF_MIRROR: begin
				rd_nxt = mirror_word;
			end
			`SMTTS_OFF_STAT_RC: begin
				rd_nxt = mirror_word;
			end
			default: begin
				rd_hit_nxt = 1'b0;
			end
		endcase
	end

	// Clear strobes, kept apart from the data mux
	always_comb begin
		rd_clr_second = 1'b0;
		rd_clr_top    = 1'b0;
		unique case (mem_addr)
			`SMTTS_OFF_TOP_RC: begin
				rd_clr_top = mem_rd_stb;
			end
			`SMTTS_OFF_STAT_RC: begin
				rd_clr_second = mem_rd_stb;
			end
			default: begin
			end
		endcase
	end

	// Data is captured before the clear lands, so nothing is lost
	assign evt.clr = rd_clr_second;

	// ==========================================================
	// Read answer state
	// Ack comes from state, not the strobe, so it never glitches
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rd_state_r <= SMTTS_RD_IDLE;
		end else begin
			unique case (rd_state_r)
				SMTTS_RD_IDLE: begin
					if (mem_rd_stb) begin
						rd_state_r <= SMTTS_RD_ANS;
					end
				end
				SMTTS_RD_ANS: begin
					if (!mem_rd_stb) begin
						rd_state_r <= SMTTS_RD_IDLE;
					end
				end
			endcase
		end
	end

	// Data holds between reads; an unmapped offset reads zero
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rd_data_r <= `SMTTS_RST_WORD;
		end else if (mem_rd_stb) begin
			rd_data_r <= rd_nxt;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rd_err_r <= 1'b0;
		end else if (mem_rd_stb) begin
			rd_err_r <= !rd_hit_nxt;
		end
	end

	assign mem_rd_data = rd_data_r;
	assign mem_rd_ack  = (rd_state_r == SMTTS_RD_ANS);
	assign mem_rd_err  = mem_rd_ack && rd_err_r;

	// ==========================================================
	// Interrupt and status outputs
	// Registered so the mirror read path never feeds the pin
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= |top_level_word(evt.status, top_r);
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			trap_status_r <= `SMTTS_RST_STAT;
		end else begin
			trap_status_r <= evt.status;
		end
	end

	assign system_mgmt_irq = irq_r;
	assign trap_status     = trap_status_r;

endmodule // smtts_top

// [smtts_monitor.sv]
`timescale 1ns/1ps
// ====================
// Status port checker
module smtts_monitor
	import smtts_pkg::*;
(
	// Clock and reset
	input wire logic                   mclk,
	input wire logic                   rst,
	// Status reads
	input wire logic                   mem_rd_stb,
	input wire smtts_pkg::smtts_byte_t mem_addr,
	input wire smtts_pkg::smtts_word_t mem_rd_data,
	input wire logic                   mem_rd_ack,
	input wire logic                   mem_rd_err,
	// Events and status
	input wire logic                   hdr_trap_stb,
	input wire smtts_pkg::smtts_func_e hdr_trap_func,
	input wire smtts_pkg::smtts_byte_t hdr_trap_idx,
	input wire logic [2:0]             ud_hit,
	input wire logic [1:0]             tmr_expire,
	input wire logic                   system_mgmt_irq,
	input wire smtts_pkg::smtts_stat_t trap_status
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// Quiet means nothing can set a bit
	wire logic quiet = !hdr_trap_stb && ud_hit == 3'h0 && tmr_expire == 2'h0;

	property p_ack;
		mem_rd_stb |=> mem_rd_ack;
	endproperty
	a_ack: assert property (p_ack) else $error("read not acked");
	property p_idle;
		!mem_rd_stb |=> !mem_rd_ack;
	endproperty
	a_idle: assert property (p_idle) else $error("stray ack");
	property p_rsvd;
		mem_rd_stb && mem_addr inside {8'h04, 8'h06}
			|=> mem_rd_data[15:6] == 10'h000;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
	property p_err;
		mem_rd_stb && !(mem_addr inside {8'h00, 8'h02, 8'h04, 8'h06})
			|=> mem_rd_err && mem_rd_data == 16'h0000;
	endproperty
	a_err: assert property (p_err) else $error("unmapped read");
	// Lag of the status copy is one cycle; a drop trails the clearing read by one or two cycles
	property p_drop;
		|($past(trap_status) & ~trap_status) |->
			($past(mem_rd_stb) && $past(mem_addr) == 8'h06) ||
			($past(mem_rd_stb, 2) && $past(mem_addr, 2) == 8'h06);
	endproperty
	a_drop: assert property (p_drop) else $error("status lost");
	property p_clr;
		mem_rd_stb && mem_addr == 8'h06 && quiet ##1 quiet
			|=> trap_status == 6'h00;
	endproperty
	a_clr: assert property (p_clr) else $error("status kept");
	property p_excl;
		!hdr_trap_stb ##1 (hdr_trap_stb && !trap_status[5] &&
			hdr_trap_func == SMTTS_FN_BRIDGE &&
			hdr_trap_idx inside {[8'h40:8'h43]}) ##1 !hdr_trap_stb
			|=> !trap_status[5];
	endproperty
	a_excl: assert property (p_excl) else $error("excluded trap");
	property p_irq;
		trap_status != 6'h00 [*3] |-> system_mgmt_irq;
	endproperty
	a_irq: assert property (p_irq) else $error("irq missing");
endmodule // smtts_monitor

bind smtts_top smtts_monitor i_mon (.mclk, .rst, .mem_rd_stb, .mem_addr,
	.mem_rd_data, .mem_rd_ack, .mem_rd_err, .hdr_trap_stb, .hdr_trap_func,
	.hdr_trap_idx, .ud_hit, .tmr_expire, .system_mgmt_irq, .trap_status);

// [smi_trap_timer_status_tb_top.sv]
`timescale 1ns/1ps
// ====================
// Bench
module smi_trap_timer_status_tb_top;
	import smtts_pkg::*;
	logic        mclk, rst, mem_rd_stb, cfg_wr_stb, cfg_rd_stb;
	logic        hdr_trap_stb, mem_rd_ack, mem_rd_err, cfg_rd_ack;
	logic        system_mgmt_irq, h;
	logic [2:0]  ud_hit, ud;
	logic [1:0]  tmr_expire, top_evt, tm;
	smtts_byte_t mem_addr, cfg_idx, cfg_wdata, cfg_rdata, hdr_trap_idx, x;
	smtts_byte_t v [4];
	smtts_byte_t ix [4] = '{8'h41, 8'h42, 8'h82, 8'h83};
	smtts_func_e hdr_trap_func, f;
	smtts_word_t mem_rd_data;
	smtts_stat_t trap_status, s;
	int          bad_count, check_count, cyc, k, j;

	smtts_top i_dut (.mclk, .rst, .mem_rd_stb, .mem_addr, .mem_rd_data,
		.mem_rd_ack, .mem_rd_err, .cfg_wr_stb, .cfg_rd_stb, .cfg_idx,
		.cfg_wdata, .cfg_rdata, .cfg_rd_ack, .hdr_trap_stb, .hdr_trap_func,
		.hdr_trap_idx, .ud_hit, .tmr_expire, .top_evt, .system_mgmt_irq,
		.trap_status);

	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	// ====================
	// Helpers
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(smtts_word_t g, smtts_word_t e);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// The rd, cw, cr and ev tasks end one edge late so strobes never toggle twice at once
	task automatic rd(smtts_byte_t a, smtts_word_t e, smtts_word_t m);
		logic bad_a;
		bad_a = !(a inside {8'h00, 8'h02, 8'h04, 8'h06});
		mem_rd_stb <= 1'b1;
		mem_addr <= a;
		@(posedge mclk);
		mem_rd_stb <= 1'b0;
		#1;
		chk({15'h0, mem_rd_ack}, 16'h0001);
		chk({15'h0, mem_rd_err}, {15'h0, bad_a});
		chk(mem_rd_data & m, e);
		@(posedge mclk);
	endtask

	task automatic cw(smtts_byte_t i, smtts_byte_t d);
		cfg_wr_stb <= 1'b1;
		cfg_idx <= i;
		cfg_wdata <= d;
		@(posedge mclk);
		cfg_wr_stb <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic cr(smtts_byte_t i, smtts_byte_t d);
		cfg_rd_stb <= 1'b1;
		cfg_idx <= i;
		@(posedge mclk);
		cfg_rd_stb <= 1'b0;
		#1;
		chk({15'h0, cfg_rd_ack}, 16'h0001);
		chk({8'h0, cfg_rdata}, {8'h0, d});
		@(posedge mclk);
	endtask

	task automatic ev(logic eh, smtts_func_e ef, smtts_byte_t ex,
		logic [2:0] eu, logic [1:0] et, logic [1:0] ep);
		hdr_trap_stb <= eh;
		hdr_trap_func <= ef;
		hdr_trap_idx <= ex;
		ud_hit <= eu;
		tmr_expire <= et;
		top_evt <= ep;
		@(posedge mclk);
		hdr_trap_stb <= 1'b0;
		ud_hit <= 3'h0;
		tmr_expire <= 2'h0;
		top_evt <= 2'h0;
		@(posedge mclk);
	endtask

	function automatic smtts_stat_t exp_st(smtts_byte_t a, b, u, t,
		logic eh, smtts_func_e ef, smtts_byte_t ex, logic [2:0] eu,
		logic [1:0] et);
		logic e;
		case (ef)
			SMTTS_FN_BRIDGE: e = a[0] && !(ex inside {[8'h40:8'h43]});
			SMTTS_FN_PWRMGMT: e = a[3];
			SMTTS_FN_DISK: e = a[6];
			SMTTS_FN_SOUND: e = b[0];
			default: e = b[1];
		endcase
		return {eh && e, eu & u[6:4], et & t[1:0]};
	endfunction

	// Hang guard, well above the expected run
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			bad_count++;
			tally_and_finish();
		end
	end

	// ====================
	// Tests
	initial begin
		void'($urandom(94393));
		rst = 1'b1;
		{mem_rd_stb, cfg_wr_stb, cfg_rd_stb, hdr_trap_stb} = 4'h0;
		{mem_addr, cfg_idx, cfg_wdata, hdr_trap_idx} = 32'h0;
		hdr_trap_func = SMTTS_FN_BRIDGE;
		{ud_hit, tmr_expire, top_evt} = 7'h00;
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		rd(8'h04, 16'h0000, 16'hFFFF);
		rd(8'h09, 16'h0000, 16'hFFFF);
		cr(8'h50, 8'h00);
		ev(1'b0, SMTTS_FN_BRIDGE, 8'h00, 3'h0, 2'h0, 2'h3);
		rd(8'h00, 16'h0003, 16'h0203);
		rd(8'h02, 16'h0003, 16'h0203);
		rd(8'h00, 16'h0000, 16'h0203);
		$display("test top done");
		// First eight are corner cases, the rest random
		for (k = 0; k < 48; k++) begin
			if (k < 8) begin
				for (j = 0; j < 4; j++) v[j] = (k == 7) ? 8'h00 : 8'hFF;
				h = (k != 6);
				f = smtts_func_e'(k % 5);
				x = (k == 0) ? 8'h43 : 8'h10;
				ud = (k > 5) ? 3'h7 : 3'h0;
				tm = (k > 5) ? 2'h3 : 2'h0;
			end else begin
				for (j = 0; j < 4; j++) v[j] = 8'($urandom);
				h = 1'($urandom);
				f = smtts_func_e'($urandom % 5);
				x = 8'($urandom);
				ud = 3'($urandom);
				tm = 2'($urandom);
			end
			for (j = 0; j < 4; j++) cw(ix[j], v[j]);
			cr(ix[k % 4], v[k % 4]);
			s = exp_st(v[0], v[1], v[2], v[3], h, f, x, ud, tm);
			ev(h, f, x, ud, tm, 2'h0);
			repeat (3) @(posedge mclk);
			chk({10'h0, trap_status}, {10'h0, s});
			chk({15'h0, system_mgmt_irq}, {15'h0, s != 6'h00});
			rd(8'h04, {10'h0, s}, 16'hFFFF);
			rd(8'h04, {10'h0, s}, 16'hFFFF);
			rd(8'h00, {6'h0, s != 6'h00, 9'h0}, 16'h0200);
			rd(8'h06, {10'h0, s}, 16'hFFFF);
			rd(8'h04, 16'h0000, 16'hFFFF);
			$display("test %0d done", k);
		end
		// Event and clearing read in one cycle: the set survives
		cw(8'h82, 8'h10);
		ud_hit <= 3'h1;
		rd(8'h06, 16'h0000, 16'hFFFF);
		ud_hit <= 3'h0;
		@(posedge mclk);
		chk({10'h0, trap_status}, 16'h0004);
		$display("test collide done");
		tally_and_finish();
	end
endmodule // smi_trap_timer_status_tb_top
